//--- hdl/sfa_pkg.sv
// Package: opcodes, status layout, states and sizes of the serial flash access slave
package sfa_pkg;
    // Opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_RD = 8'h05;
    localparam logic [7:0] OP_STATUS_WR = 8'h01;
    localparam logic [7:0] OP_ARRAY_RD = 8'h03;
    localparam logic [7:0] OP_ARRAY_WR = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_WHOLE_ERASE = 8'h60;
    // Status word layout
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LATCH_BIT = 1;
    localparam int STAT_PROT_LO_BIT = 2;
    localparam int STAT_PROT_HI_BIT = 3;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [1:0] PROT_RESET = 2'h0;
    // Array geometry
    localparam int ARRAY_ADDR_W = 9;
    localparam logic [8:0] BASE_LAST_ADDR = 9'h0ff;
    localparam int EXT_WORD_W = 16;
    localparam int BASE_WORD_W = 8;
    localparam int FIFO_DEPTH_DEF = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA_IN = 3'b011,
        ST_READ = 3'b100,
        ST_STATUS_OUT = 3'b101,
        ST_STATUS_IN = 3'b110,
        ST_WAIT = 3'b111
    } sfa_state_type;
endpackage : sfa_pkg

//--- hdl/sfa_word_fifo.sv
// Word FIFO in flip-flops between the array read port and the serial shifter
module sfa_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != FULL_CNT);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : sfa_word_fifo

//--- hdl/sfa_spi_flash_slave.sv
// Serial peripheral slave giving a bus master access to the user flash array
// ==========================================================================
// Summary of operation
// - Each serial_in bit is captured on a rising serial_clock edge.
// - serial_out changes on falling serial_clock edges only.
// - Deselected: inputs ignored, serial_out released to high impedance.
// - Fields shift most significant bit first; each frame opens on select falling.
// - An unknown first byte makes the slave ignore input until deselect.
// - Deselect returns the slave to idle; each request needs a new select.
// - Opcodes 06 set, 04 clear the write latch; 05 reads status.
// - Opcode 01 writes the status word, updating the protection bits.
// - Opcode 03 reads the array, 02 writes it.
// - Opcode 20 erases one sector, 60 erases the whole array.
// - Base mode: 8-bit words, sector 0; Extended: 16-bit words, both sectors.
// - Status bits 7..4 read zero, bits 3..2 hold protection; reset zero.
// - Status bit 1 is the write latch enabling array writes.
// - Status bit 0 shows a running internal write or erase cycle.
// - Read-only build holds no latch, protection or busy status.
// - Array write only with latch set and address unprotected, else skip data.
// - Extended address is 16 bits; only the last nine are kept.
// - Array read opcode ignored while programming is in progress.
// - Read streams consecutive words until select goes high or a base read passes 255.
// - Extended read wraps from the last location to the first.
// - Base read takes an 8-bit address then streams bytes.
// - Base read stops at 255; serial_out floats after its eighth bit.
// - ring_oscillator_enable stays asserted whenever the slave exists.
module sfa_spi_flash_slave #(
    parameter bit EXTENDED = 1'b1,
    parameter bit READ_ONLY = 1'b0,
    parameter int FIFO_DEPTH = sfa_pkg::FIFO_DEPTH_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic select_low,
    output logic serial_out,
    output logic serial_out_oe,
    output logic ring_oscillator_enable,
    output logic [sfa_pkg::ARRAY_ADDR_W-1:0] flash_addr,
    output logic flash_rd_req,
    input wire logic flash_rd_valid,
    input wire logic [sfa_pkg::EXT_WORD_W-1:0] flash_rd_data,
    output logic flash_wr_req,
    output logic [sfa_pkg::EXT_WORD_W-1:0] flash_wr_data,
    output logic flash_erase_req,
    output logic flash_erase_all,
    output logic flash_erase_sector,
    input wire logic flash_busy
);
    // ======================================================================
    // Sizes
    localparam int WORD_W = EXTENDED ? sfa_pkg::EXT_WORD_W : sfa_pkg::BASE_WORD_W;
    localparam logic [4:0] OP_LAST = 5'd7;
    localparam logic [4:0] ADDR_LAST = 5'(WORD_W - 1);
    localparam logic [4:0] WORD_LAST = 5'(WORD_W - 1);
    localparam logic [4:0] STAT_LAST = 5'd7;

    // ======================================================================
    // Pin synchronisers
    logic sclk_s1, sclk_s2, sclk_d3;
    logic cs_s1, cs_s2, cs_d3;
    logic si_s1, si_s2;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_d3 <= 1'b1;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
        end else begin
            sclk_s1 <= serial_clock;
            sclk_s2 <= sclk_s1;
            sclk_d3 <= sclk_s2;
            cs_s1 <= select_low;
            cs_s2 <= cs_s1;
            cs_d3 <= cs_s2;
            si_s1 <= serial_in;
            si_s2 <= si_s1;
        end
    end

    logic cs_start, cs_end, rise_e, fall_e;
    assign cs_start = cs_d3 && !cs_s2;
    assign cs_end = !cs_d3 && cs_s2;
    // Clock edges only count while selected
    assign rise_e = sclk_s2 && !sclk_d3 && !cs_s2 && !cs_d3;
    assign fall_e = !sclk_s2 && sclk_d3 && !cs_s2 && !cs_d3;

    // ======================================================================
    // Receive path and command sequencing
    sfa_pkg::sfa_state_type state_r;
    logic [15:0] rx_r;
    logic [15:0] rx_nxt;
    logic [4:0] bit_cnt_r;
    logic [7:0] opcode_r;
    logic latch_r;
    logic [1:0] prot_r;
    logic [sfa_pkg::ARRAY_ADDR_W-1:0] addr_r;
    logic [sfa_pkg::ARRAY_ADDR_W-1:0] addr_word;
    logic op_done, addr_done, data_done, stat_done;

    assign rx_nxt = {rx_r[14:0], si_s2};
    assign op_done = rise_e && (state_r == sfa_pkg::ST_OPCODE) && (bit_cnt_r == OP_LAST);
    assign addr_done = rise_e && (state_r == sfa_pkg::ST_ADDR) && (bit_cnt_r == ADDR_LAST);
    assign data_done = rise_e && (state_r == sfa_pkg::ST_DATA_IN) && (bit_cnt_r == WORD_LAST);
    assign stat_done = rise_e && (state_r == sfa_pkg::ST_STATUS_IN) && (bit_cnt_r == STAT_LAST);
    // Upper seven address bits fall away in Extended mode
    assign addr_word = EXTENDED ? rx_nxt[8:0] : {1'b0, rx_nxt[7:0]};

    // Protection levels cover none, upper quarter, upper half, all
    function automatic logic prot_hit(input logic [1:0] lvl,
                                      input logic [sfa_pkg::ARRAY_ADDR_W-1:0] a);
        logic [1:0] top;
        top = EXTENDED ? a[8:7] : a[7:6];
        case (lvl)
            2'h0: prot_hit = 1'b0;
            2'h1: prot_hit = (top == 2'h3);
            2'h2: prot_hit = top[1];
            default: prot_hit = 1'b1;
        endcase
    endfunction : prot_hit

    function automatic sfa_pkg::sfa_state_type decode(input logic [7:0] op,
                                                       input logic busy);
        decode = sfa_pkg::ST_WAIT;
        // While programming only the status read is honoured
        if (!busy || (op == sfa_pkg::OP_STATUS_RD && !READ_ONLY)) begin
            case (op)
                sfa_pkg::OP_ARRAY_RD: decode = sfa_pkg::ST_ADDR;
                sfa_pkg::OP_ARRAY_WR: decode = READ_ONLY ? sfa_pkg::ST_WAIT : sfa_pkg::ST_ADDR;
                sfa_pkg::OP_SECTOR_ERASE: begin
                    decode = (EXTENDED && !READ_ONLY) ? sfa_pkg::ST_ADDR : sfa_pkg::ST_WAIT;
                end
                sfa_pkg::OP_STATUS_RD: begin
                    decode = READ_ONLY ? sfa_pkg::ST_WAIT : sfa_pkg::ST_STATUS_OUT;
                end
                sfa_pkg::OP_STATUS_WR: begin
                    decode = READ_ONLY ? sfa_pkg::ST_WAIT : sfa_pkg::ST_STATUS_IN;
                end
                default: decode = sfa_pkg::ST_WAIT;
            endcase
        end
    endfunction : decode

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= sfa_pkg::ST_IDLE;
            rx_r <= '0;
            bit_cnt_r <= '0;
            opcode_r <= '0;
        end else if (cs_end || cs_s2) begin
            state_r <= sfa_pkg::ST_IDLE;
            bit_cnt_r <= '0;
        end else if (cs_start) begin
            state_r <= sfa_pkg::ST_OPCODE;
            bit_cnt_r <= '0;
        end else if (rise_e) begin
            rx_r <= rx_nxt;
            bit_cnt_r <= bit_cnt_r + 5'd1;
            case (state_r)
                sfa_pkg::ST_OPCODE: begin
                    if (op_done) begin
                        opcode_r <= rx_nxt[7:0];
                        state_r <= decode(rx_nxt[7:0], flash_busy);
                        bit_cnt_r <= '0;
                    end
                end
                sfa_pkg::ST_ADDR: begin
                    if (addr_done) begin
                        bit_cnt_r <= '0;
                        if (opcode_r == sfa_pkg::OP_ARRAY_RD) begin
                            state_r <= sfa_pkg::ST_READ;
                        end else if (opcode_r == sfa_pkg::OP_ARRAY_WR && latch_r
                                     && !prot_hit(prot_r, addr_word)) begin
                            state_r <= sfa_pkg::ST_DATA_IN;
                        end else begin
                            state_r <= sfa_pkg::ST_WAIT;
                        end
                    end
                end
                sfa_pkg::ST_DATA_IN, sfa_pkg::ST_STATUS_IN: begin
                    if (data_done || stat_done) begin
                        state_r <= sfa_pkg::ST_WAIT;
                    end
                end
                default: state_r <= state_r;
            endcase
        end
    end

    // ======================================================================
    // Status word; absent in the read-only build
    logic [7:0] status_byte;
    assign status_byte = {4'h0, prot_r, latch_r, READ_ONLY ? 1'b0 : flash_busy};

    always_ff @(posedge sys_clk) begin
        if (rst || READ_ONLY) begin
            latch_r <= sfa_pkg::STAT_RESET[sfa_pkg::STAT_LATCH_BIT];
            prot_r <= sfa_pkg::PROT_RESET;
        end else begin
            if (op_done && !flash_busy && rx_nxt[7:0] == sfa_pkg::OP_SET_LATCH) begin
                latch_r <= 1'b1;
            end else if (op_done && !flash_busy && rx_nxt[7:0] == sfa_pkg::OP_CLR_LATCH) begin
                latch_r <= 1'b0;
            end
            if (stat_done) begin
                prot_r <= {rx_nxt[sfa_pkg::STAT_PROT_HI_BIT],
                           rx_nxt[sfa_pkg::STAT_PROT_LO_BIT]};
            end
        end
    end

    // ======================================================================
    // Write and erase requests launch only when the frame closes
    logic wr_arm_r, er_arm_r, er_all_r;
    logic wr_req_r, er_req_r, er_sector_r;
    logic [15:0] wr_data_r;

    always_ff @(posedge sys_clk) begin
        if (rst || READ_ONLY) begin
            wr_arm_r <= 1'b0;
            er_arm_r <= 1'b0;
            er_all_r <= 1'b0;
            wr_req_r <= 1'b0;
            er_req_r <= 1'b0;
            er_sector_r <= 1'b0;
            wr_data_r <= '0;
        end else begin
            wr_req_r <= cs_end && wr_arm_r;
            er_req_r <= cs_end && er_arm_r;
            if (cs_start || cs_end) begin
                wr_arm_r <= 1'b0;
                er_arm_r <= 1'b0;
            end
            if (data_done) begin
                wr_arm_r <= 1'b1;
                wr_data_r <= EXTENDED ? rx_nxt : {8'h00, rx_nxt[7:0]};
            end
            // Erase needs the latch and no protection at all
            if (op_done && !flash_busy && latch_r && prot_r == sfa_pkg::PROT_RESET) begin
                if (rx_nxt[7:0] == sfa_pkg::OP_WHOLE_ERASE) begin
                    er_arm_r <= 1'b1;
                    er_all_r <= EXTENDED;
                    er_sector_r <= 1'b0;
                end else if (!EXTENDED && rx_nxt[7:0] == sfa_pkg::OP_SECTOR_ERASE) begin
                    er_arm_r <= 1'b1;
                    er_all_r <= 1'b0;
                    er_sector_r <= 1'b0;
                end
            end
            if (addr_done && opcode_r == sfa_pkg::OP_SECTOR_ERASE && latch_r
                && prot_r == sfa_pkg::PROT_RESET) begin
                er_arm_r <= 1'b1;
                er_all_r <= 1'b0;
                er_sector_r <= addr_word[8];
            end
        end
    end

    assign flash_wr_req = wr_req_r;
    assign flash_wr_data = wr_data_r;
    assign flash_erase_req = er_req_r;
    assign flash_erase_all = er_all_r;
    assign flash_erase_sector = er_sector_r;
    assign ring_oscillator_enable = 1'b1;

    // ======================================================================
    // Read prefetch into the FIFO; the array port is held off when it fills
    logic rd_pend_r, pf_done_r, fetch_en, fifo_flush;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [15:0] fifo_out_data;

    assign fetch_en = (state_r == sfa_pkg::ST_READ) && !pf_done_r && !rd_pend_r
                      && fifo_in_ready;
    assign fifo_flush = addr_done || cs_end;
    assign flash_rd_req = fetch_en;
    assign flash_addr = addr_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_r <= '0;
            rd_pend_r <= 1'b0;
            pf_done_r <= 1'b0;
        end else begin
            if (flash_rd_valid) begin
                rd_pend_r <= 1'b0;
            end
            if (addr_done) begin
                addr_r <= addr_word;
                pf_done_r <= 1'b0;
            end else if (fetch_en) begin
                rd_pend_r <= 1'b1;
                addr_r <= addr_r + 9'd1;
                if (!EXTENDED && addr_r == sfa_pkg::BASE_LAST_ADDR) begin
                    pf_done_r <= 1'b1;
                end
            end
        end
    end

    sfa_word_fifo #(
        .WIDTH(sfa_pkg::EXT_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(fifo_flush),
        .in_valid(flash_rd_valid && rd_pend_r && state_r == sfa_pkg::ST_READ),
        .in_ready(fifo_in_ready),
        .in_data(flash_rd_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ======================================================================
    // Transmit shifter, driven on falling serial clock edges
    logic [15:0] tx_r;
    logic [4:0] tx_cnt_r;
    logic so_r, oe_r;
    logic [15:0] word_aligned;

    assign fifo_pop = fall_e && state_r == sfa_pkg::ST_READ && tx_cnt_r == '0
                      && fifo_out_valid;
    assign word_aligned = EXTENDED ? fifo_out_data : {fifo_out_data[7:0], 8'h00};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_r <= '0;
            tx_cnt_r <= '0;
            so_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (cs_s2 || state_r == sfa_pkg::ST_IDLE) begin
            oe_r <= 1'b0;
            tx_cnt_r <= '0;
        end else if (fall_e) begin
            if (tx_cnt_r != '0) begin
                so_r <= tx_r[15];
                tx_r <= {tx_r[14:0], 1'b0};
                tx_cnt_r <= tx_cnt_r - 5'd1;
            end else if (state_r == sfa_pkg::ST_STATUS_OUT) begin
                so_r <= status_byte[7];
                tx_r <= {status_byte[6:0], 9'h000};
                tx_cnt_r <= STAT_LAST;
                oe_r <= 1'b1;
            end else if (fifo_pop) begin
                so_r <= word_aligned[15];
                tx_r <= {word_aligned[14:0], 1'b0};
                tx_cnt_r <= WORD_LAST;
                oe_r <= 1'b1;
            end else if (state_r == sfa_pkg::ST_READ && pf_done_r) begin
                oe_r <= 1'b0;
            end
        end
    end

    assign serial_out = so_r;
    assign serial_out_oe = oe_r;

    // ======================================================================
    // Checks
    sequence s_read_start;
        addr_done && opcode_r == sfa_pkg::OP_ARRAY_RD;
    endsequence
    sequence s_base_last_fetch;
        fetch_en && !EXTENDED && addr_r == sfa_pkg::BASE_LAST_ADDR;
    endsequence

    a_deselect_float: assert property (@(posedge sys_clk) disable iff (rst)
        cs_s2 |=> !serial_out_oe)
        else $error("serial_out driven while deselected");
    a_out_on_fall: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(serial_out) |-> $past(fall_e))
        else $error("serial_out changed without a falling clock edge");
    a_busy_ignores: assert property (@(posedge sys_clk) disable iff (rst)
        op_done && flash_busy && rx_nxt[7:0] == sfa_pkg::OP_ARRAY_RD |=>
        state_r == sfa_pkg::ST_WAIT)
        else $error("array read accepted while busy");
    a_wait_holds: assert property (@(posedge sys_clk) disable iff (rst)
        state_r == sfa_pkg::ST_WAIT && !cs_s2 && !cs_start |=> state_r == sfa_pkg::ST_WAIT)
        else $error("ignored frame left wait before deselect");
    a_end_idle: assert property (@(posedge sys_clk) disable iff (rst)
        cs_end |=> state_r == sfa_pkg::ST_IDLE ##1 !serial_out_oe)
        else $error("slave not idle after deselect");
    a_read_stream: assert property (@(posedge sys_clk) disable iff (rst)
        s_read_start |=> state_r == sfa_pkg::ST_READ && addr_r == $past(addr_word))
        else $error("read did not start at the received address");
    a_base_stop: assert property (@(posedge sys_clk) disable iff (rst)
        s_base_last_fetch |=> pf_done_r && !flash_rd_req)
        else $error("base read fetched past the last address");
    a_ext_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        fetch_en && EXTENDED && addr_r == 9'h1ff |=> addr_r == 9'h000)
        else $error("extended read address did not wrap");
    a_write_gated: assert property (@(posedge sys_clk) disable iff (rst)
        flash_wr_req |-> latch_r && !READ_ONLY && $past(cs_end))
        else $error("array write issued without the write latch");
    a_latch_set: assert property (@(posedge sys_clk) disable iff (rst)
        op_done && !flash_busy && !READ_ONLY && rx_nxt[7:0] == sfa_pkg::OP_SET_LATCH
        |=> latch_r ##1 status_byte[sfa_pkg::STAT_LATCH_BIT])
        else $error("write latch not set by its opcode");
    a_prot_update: assert property (@(posedge sys_clk) disable iff (rst)
        stat_done && !READ_ONLY |=> prot_r == $past({rx_nxt[3], rx_nxt[2]})
        && status_byte[7:4] == 4'h0)
        else $error("protection bits not taken from status write");
    a_osc_on: assert property (@(posedge sys_clk) disable iff (rst)
        ring_oscillator_enable)
        else $error("oscillator enable dropped");
endmodule : sfa_spi_flash_slave

//--- tb/sfa_spi_master.sv
// Bus master model that drives the serial link of the flash access slave
module sfa_spi_master (
    output logic serial_clock,
    output logic serial_in,
    output logic select_low,
    input wire logic miso,
    output logic [15:0] rx_word,
    output logic rx_stb
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Link driving
    initial begin
        serial_clock = 1'b0;
        serial_in = 1'b0;
        select_low = 1'b1;
        rx_word = 16'h0000;
        rx_stb = 1'b0;
    end
    task automatic sel();
        select_low = 1'b0;
        #50;
    endtask : sel
    // Clock stands low outside frames; data moves while it is low
    task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = tx[i];
            #62.5 serial_clock = 1'b1;
            rx[i] = miso;
            #62.5 serial_clock = 1'b0;
        end
        // Inverted so a stale level is never mistaken for real data
        serial_in = ~serial_in;
    endtask : xfer
    task automatic rd(input int n);
        logic [15:0] r;
        xfer(n, 16'h0000, r);
        rx_word = r;
        rx_stb = ~rx_stb;
    endtask : rd
    task automatic desel();
        #30 select_low = 1'b1;
        #100;
    endtask : desel
endmodule : sfa_spi_master

//--- tb/sfa_spi_flash_slave_bench.sv
// Self-checking bench of the serial flash access slave
module sfa_spi_flash_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, rst = 1'b1, flash_busy = 1'b0, flash_rd_valid = 1'b0, oe_seen;
    logic [15:0] flash_rd_data, r;
    wire logic sck, mosi, cs_n, so, so_oe, osc, rd_req, wr_req, er_req, er_all, er_sect, rx_stb;
    wire logic [8:0] faddr;
    wire logic [15:0] wdata, rx_word;
    wire logic miso = so_oe ? so : 1'bz;
    logic [31:0] exp_q[$];
    int fail_count = 0, checks_done = 0, seed = 65;
    always #5 sys_clk = ~sys_clk;
    sfa_spi_flash_slave uut (.sys_clk(sys_clk), .rst(rst), .serial_clock(sck),
        .serial_in(mosi), .select_low(cs_n), .serial_out(so), .serial_out_oe(so_oe),
        .ring_oscillator_enable(osc), .flash_addr(faddr), .flash_rd_req(rd_req),
        .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
        .flash_wr_req(wr_req), .flash_wr_data(wdata), .flash_erase_req(er_req),
        .flash_erase_all(er_all), .flash_erase_sector(er_sect), .flash_busy(flash_busy));
    sfa_spi_master mst (.serial_clock(sck), .serial_in(mosi), .select_low(cs_n),
        .miso(miso), .rx_word(rx_word), .rx_stb(rx_stb));
    // ==========================================================
    // Array model answering one cycle after each request
    function automatic logic [15:0] fdat(input logic [8:0] a);
        return {7'h29, a} ^ {a[7:0], 8'h00};
    endfunction : fdat
    always @(posedge sys_clk) begin
        logic v;
        logic [8:0] a;
        v = rd_req;
        a = faddr;
        #1 flash_rd_valid = v;
        flash_rd_data = fdat(a);
    end
    // ==========================================================
    // Result watchers
    task automatic take(input logic [31:0] got);
        logic [31:0] e;
        checks_done++;
        e = (exp_q.size() == 0) ? 32'hdead_0000 : exp_q.pop_front();
        if (got !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : take
    // The strobe settles from unknown at time zero; that is not a received word
    always @(rx_stb) if (!rst) take({16'h0000, rx_word});
    always @(posedge sys_clk) begin
        if (so_oe === 1'b1) oe_seen = 1'b1;
        if (wr_req === 1'b1) take({7'h00, faddr, wdata});
        if (er_req === 1'b1) take({30'h0, er_sect, er_all});
    end
    // ==========================================================
    // Frame helpers
    task automatic frame(input logic [7:0] op, input int n, input logic [15:0] d);
        mst.sel();
        mst.xfer(8, {8'h00, op}, r);
        if (n > 0) mst.xfer(n, d, r);
        mst.desel();
    endtask : frame
    task automatic wr_frame(input logic [15:0] a, input logic [15:0] d);
        mst.sel();
        mst.xfer(8, 16'h0002, r);
        mst.xfer(16, a, r);
        mst.xfer(16, d, r);
        mst.desel();
    endtask : wr_frame
    task automatic stat(input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        mst.sel();
        mst.xfer(8, 16'h0005, r);
        mst.rd(8);
        mst.desel();
    endtask : stat
    task automatic rd(input logic [15:0] addr, input int n);
        logic [8:0] a;
        a = addr[8:0];
        mst.sel();
        mst.xfer(8, 16'h0003, r);
        mst.xfer(16, addr, r);
        repeat (n) begin
            exp_q.push_back({16'h0, fdat(a)});
            a++;
            mst.rd(16);
        end
        mst.desel();
    endtask : rd
    // Refused frames must never turn the output driver on
    task automatic refused(input logic [7:0] op);
        oe_seen = 1'b0;
        exp_q.push_back(32'h0);
        frame(op, 16, 16'h0300);
        take({31'h0, oe_seen});
    endtask : refused
    task automatic stop_test();
        fail_count += exp_q.size();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (5) @(posedge sys_clk);
        exp_q.push_back(32'h1);
        take({31'h0, osc});
        stat(8'h00);
        frame(8'h06, 0, 16'h0);
        stat(8'h02);
        frame(8'h04, 0, 16'h0);
        stat(8'h00);
        frame(8'h01, 8, 16'h00ff);
        stat(8'h0c);
        frame(8'h01, 8, 16'h0000);
        @(posedge sys_clk) #1 flash_busy = 1'b1;
        stat(8'h01);
        refused(8'h03);
        @(posedge sys_clk) #1 flash_busy = 1'b0;
        refused(8'ha5);
        rd(16'hfffe, 3);
        repeat (3) rd($random(seed), 2);
        frame(8'h06, 0, 16'h0);
        exp_q.push_back({7'h00, 9'h123, 16'hbeef});
        wr_frame(16'hfd23, 16'hbeef);
        frame(8'h04, 0, 16'h0);
        wr_frame(16'h0042, 16'h1234);
        frame(8'h06, 0, 16'h0);
        exp_q.push_back(32'h1);
        frame(8'h60, 0, 16'h0);
        exp_q.push_back(32'h2);
        frame(8'h20, 16, 16'h0100);
        repeat (20) @(posedge sys_clk);
        stop_test();
    end
    initial begin
        #800us;
        fail_count++;
        stop_test();
    end
endmodule : sfa_spi_flash_slave_bench
